//--- verilog/adc_seq_pkg.sv
// Shared constants, register map and types of the conversion sequencer.
package adc_seq_pkg;
    // Register word indices; byte address is four times the index.
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_CTRL1 = 4'h1;
    localparam logic [3:0] ADR_CTRL2 = 4'h2;
    localparam logic [3:0] ADR_RSEQ0 = 4'h3;
    localparam logic [3:0] ADR_RSEQ1 = 4'h4;
    localparam logic [3:0] ADR_RSEQ2 = 4'h5;
    localparam logic [3:0] ADR_JSEQ = 4'h6;
    localparam logic [3:0] ADR_HTHR = 4'h7;
    localparam logic [3:0] ADR_LTHR = 4'h8;
    localparam logic [3:0] ADR_RRES = 4'h9;
    localparam logic [3:0] ADR_JRES = 4'ha;
    // Status bits.
    localparam int ST_EOC = 0;
    localparam int ST_INJECTED_DONE_FLAG = 1;
    localparam int ST_AWD = 2;
    localparam int ST_PWR = 3;
    localparam int ST_BUSY = 4;
    // Control one bits.
    localparam int C1_GSEL = 0;
    localparam int C1_REGULAR_DONE_IRQ_EN = 5;
    localparam int C1_THRESHOLD_ALARM_IRQ_EN = 6;
    localparam int C1_INJECTED_DONE_IRQ_EN = 7;
    localparam int C1_GSGL = 8;
    localparam int C1_AUTO_INJECT_ENABLE = 9;
    localparam int C1_GJEN = 10;
    localparam int C1_GREN = 11;
    // Control two bits.
    localparam int C2_PWR = 0;
    localparam int C2_REP = 1;
    localparam int C2_PRE = 2;
    localparam int C2_RSTART = 4;
    localparam int C2_JSTART = 5;
    localparam int C2_TEMP = 6;
    localparam int C2_VBAT = 7;
    // Sequence length fields.
    localparam int SQ_RLEN = 20;
    localparam int SQ_JLEN = 20;
    localparam int SQ_ENT = 5;
    // Reset values and counts.
    localparam logic [11:0] RST_HTHR = 12'hfff;
    localparam logic [11:0] RST_LTHR = 12'h000;
    localparam logic [3:0] CONV_CYCLES = 4'hf;
    localparam logic [4:0] CH_TEMP_A = 5'h10;
    localparam logic [4:0] CH_VREF = 5'h11;
    localparam logic [4:0] CH_TEMP_B = 5'h12;

    typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_CONV} state_t;

    typedef struct packed {
        logic power;
        logic conv_clk;
        logic convert;
        logic [4:0] channel;
        logic temp_sel;
        logic vbat_sel;
        logic vref_sel;
    } ana_ctrl_t;
endpackage

//--- verilog/adc_conv_seq.sv
// Conversion sequencer of a successive-approximation converter with Avalon-MM registers.
// Notes on behaviour
// R01 - First power-on bit set only powers up.
// R02 - Regular or injected soft start begins conversion.
// R03 - Clearing power bit stops and powers down.
// R04 - Conversion clock is bus clock divided 2/4/6/8.
// R05 - Register access runs on bus clock.
// R06 - Sixteen external channels, any order, repeats allowed.
// R07 - Regular group up to 16, 4-bit length.
// R08 - Injected group up to 4, 2-bit length.
// R09 - Sequence write while converting restarts the group.
// R10 - Internal reference sits on channel 17.
// R11 - Channels 16/18 shared; battery monitor wins.
// R12 - Repeat off: one conversion, then stop.
// R13 - Regular result stored, regular done flag set.
// R14 - Injected result stored, injected done flag set.
// R15 - Repeat on: regular restarts after each finish.
// R16 - Injected repeats only with auto injection.
// R17 - Done and result 15 conversion clocks after start.
// R18 - Alarm when result outside 12-bit thresholds.
// R19 - Alarm interrupt when its enable is set.
// R20 - Thresholds compare raw unaligned result.
// R21 - Single, regular and injected guard selection bits.
// R22 - 5-bit select names the single guarded channel.
// R23 - Flags sticky until cleared; interrupt is flag and enable.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
module adc_conv_seq (
    input wire logic ref_clk_i, // Bus clock.
    input wire logic sys_rst_i, // Synchronous reset, active high.
    input wire logic [3:0] avs_address_i, // Word address.
    input wire logic avs_read_i, // Read request.
    input wire logic avs_write_i, // Write request.
    input wire logic [31:0] avs_writedata_i, // Write data.
    output logic [31:0] avs_readdata_o, // Read data.
    output logic avs_waitrequest_o, // Stall.
    input wire logic ext_reg_trig_i, // Regular trigger pulse.
    input wire logic ext_inj_trig_i, // Injected trigger pulse.
    input wire logic [11:0] result_i, // Raw result from the analog core.
    output adc_seq_pkg::ana_ctrl_t ana_o, // Analog core control.
    output logic irq_eoc_o, // Regular done interrupt.
    output logic irq_injected_done_flag_o, // Injected done interrupt.
    output logic irq_awd_o // Threshold alarm interrupt.
);
    localparam int NREG = 16;
    localparam int NINJ = 4;

    logic wait_r;
    logic [31:0] rdata_r;
    logic power_on_bit_r, repeat_mode_bit_r, temp_en_r, vbat_en_r;
    logic [1:0] pre_r;
    logic [4:0] guarded_channel_select_r;
    logic regular_done_irq_en_r, threshold_alarm_irq_en_r, injected_done_irq_en_r;
    logic guard_single_channel_r, auto_inject_enable_r;
    logic guard_injected_enable_r, guard_regular_enable_r;
    logic [4:0] rseq_r [NREG];
    logic [4:0] jseq_r [NINJ];
    logic [3:0] rlen_r;
    logic [1:0] jlen_r;
    logic [11:0] hthr_r, lthr_r;
    logic [15:0] rres_r, jres_r;
    logic eoc_r, injected_done_flag_r, threshold_alarm_flag_r;
    adc_seq_pkg::state_t state_r;
    logic inj_r, res_r;
    logic [3:0] idx_r, sav_r, cyc_r;
    logic [2:0] pc_r;
    adc_seq_pkg::ana_ctrl_t ana_r;
    logic irq_eoc_r, irq_injected_done_flag_r, irq_awd_r;

    logic acc, wr, pwr_up, pwr_dn, reg_start, inj_start, seq_wr;
    logic tick, done, guarded, out_range, rlast, jlast;
    logic [2:0] pc_last, pc_nxt;
    logic [4:0] cur_ch;
    logic [31:0] wd;

    assign wd = avs_writedata_i;
    assign acc = (avs_read_i | avs_write_i) & ~wait_r;
    assign wr = avs_write_i & ~wait_r;
    assign pwr_up = wr && avs_address_i == adc_seq_pkg::ADR_CTRL2
        && wd[adc_seq_pkg::C2_PWR] && !power_on_bit_r; // [R01]
    assign pwr_dn = wr && avs_address_i == adc_seq_pkg::ADR_CTRL2
        && !wd[adc_seq_pkg::C2_PWR]; // [R03]
    // Starts count only once powered; the powering write itself starts nothing.
    assign reg_start = (state_r != adc_seq_pkg::ST_OFF) && !pwr_up && !pwr_dn
        && (ext_reg_trig_i || (wr && avs_address_i == adc_seq_pkg::ADR_CTRL2
        && wd[adc_seq_pkg::C2_RSTART])); // [R02]
    assign inj_start = (state_r != adc_seq_pkg::ST_OFF) && !pwr_up && !pwr_dn
        && (ext_inj_trig_i || (wr && avs_address_i == adc_seq_pkg::ADR_CTRL2
        && wd[adc_seq_pkg::C2_JSTART])); // [R02]
    assign seq_wr = wr && (avs_address_i == adc_seq_pkg::ADR_RSEQ0
        || avs_address_i == adc_seq_pkg::ADR_RSEQ1
        || avs_address_i == adc_seq_pkg::ADR_RSEQ2
        || avs_address_i == adc_seq_pkg::ADR_JSEQ);

    // Prescaler: one conversion clock period spans 2*(pre+1) bus clocks.
    assign pc_last = {pre_r, 1'b1}; // [R04]
    // A lowered prescale can leave the counter past its new end; wrap it at once.
    assign tick = pc_r >= pc_last;
    assign pc_nxt = tick ? 3'h0 : pc_r + 3'h1;
    assign done = state_r == adc_seq_pkg::ST_CONV && tick
        && cyc_r == adc_seq_pkg::CONV_CYCLES - 4'h1; // [R17]
    assign cur_ch = inj_r ? jseq_r[idx_r[1:0]] : rseq_r[idx_r]; // [R06]
    assign rlast = idx_r == rlen_r; // [R07]
    assign jlast = idx_r[1:0] == jlen_r; // [R08]
    assign guarded = (inj_r ? guard_injected_enable_r : guard_regular_enable_r)
        && (!guard_single_channel_r || cur_ch == guarded_channel_select_r); // [R21] [R22]
    assign out_range = result_i < lthr_r || result_i > hthr_r; // [R18] [R20]

    // Avalon slave: a request is answered one cycle after it appears.
    always_ff @(posedge ref_clk_i) begin // [R05]
        if (sys_rst_i) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((avs_read_i || avs_write_i) && wait_r);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_i && wait_r) begin
            rdata_r <= 32'h0000_0000;
            case (avs_address_i)
                adc_seq_pkg::ADR_STATUS: begin
                    rdata_r[adc_seq_pkg::ST_EOC] <= eoc_r;
                    rdata_r[adc_seq_pkg::ST_INJECTED_DONE_FLAG] <= injected_done_flag_r;
                    rdata_r[adc_seq_pkg::ST_AWD] <= threshold_alarm_flag_r;
                    rdata_r[adc_seq_pkg::ST_PWR] <= power_on_bit_r;
                    rdata_r[adc_seq_pkg::ST_BUSY] <= state_r == adc_seq_pkg::ST_CONV;
                end
                adc_seq_pkg::ADR_CTRL1: begin
                    rdata_r[adc_seq_pkg::C1_GSEL +: 5] <= guarded_channel_select_r;
                    rdata_r[adc_seq_pkg::C1_REGULAR_DONE_IRQ_EN] <= regular_done_irq_en_r;
                    rdata_r[adc_seq_pkg::C1_THRESHOLD_ALARM_IRQ_EN] <= threshold_alarm_irq_en_r;
                    rdata_r[adc_seq_pkg::C1_INJECTED_DONE_IRQ_EN] <= injected_done_irq_en_r;
                    rdata_r[adc_seq_pkg::C1_GSGL] <= guard_single_channel_r;
                    rdata_r[adc_seq_pkg::C1_AUTO_INJECT_ENABLE] <= auto_inject_enable_r;
                    rdata_r[adc_seq_pkg::C1_GJEN] <= guard_injected_enable_r;
                    rdata_r[adc_seq_pkg::C1_GREN] <= guard_regular_enable_r;
                end
                adc_seq_pkg::ADR_CTRL2: begin
                    rdata_r[adc_seq_pkg::C2_PWR] <= power_on_bit_r;
                    rdata_r[adc_seq_pkg::C2_REP] <= repeat_mode_bit_r;
                    rdata_r[adc_seq_pkg::C2_PRE +: 2] <= pre_r;
                    rdata_r[adc_seq_pkg::C2_TEMP] <= temp_en_r;
                    rdata_r[adc_seq_pkg::C2_VBAT] <= vbat_en_r;
                end
                adc_seq_pkg::ADR_RSEQ0: begin
                    for (int i = 0; i < 6; i++) begin
                        rdata_r[i*5 +: 5] <= rseq_r[i];
                    end
                end
                adc_seq_pkg::ADR_RSEQ1: begin
                    for (int i = 0; i < 6; i++) begin
                        rdata_r[i*5 +: 5] <= rseq_r[i+6];
                    end
                end
                adc_seq_pkg::ADR_RSEQ2: begin
                    for (int i = 0; i < 4; i++) begin
                        rdata_r[i*5 +: 5] <= rseq_r[i+12];
                    end
                    rdata_r[adc_seq_pkg::SQ_RLEN +: 4] <= rlen_r;
                end
                adc_seq_pkg::ADR_JSEQ: begin
                    for (int i = 0; i < NINJ; i++) begin
                        rdata_r[i*5 +: 5] <= jseq_r[i];
                    end
                    rdata_r[adc_seq_pkg::SQ_JLEN +: 2] <= jlen_r;
                end
                adc_seq_pkg::ADR_HTHR: rdata_r[11:0] <= hthr_r;
                adc_seq_pkg::ADR_LTHR: rdata_r[11:0] <= lthr_r;
                adc_seq_pkg::ADR_RRES: rdata_r[15:0] <= rres_r;
                adc_seq_pkg::ADR_JRES: rdata_r[15:0] <= jres_r;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Control registers.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            power_on_bit_r <= 1'b0;
            repeat_mode_bit_r <= 1'b0;
            pre_r <= 2'h0;
            temp_en_r <= 1'b0;
            vbat_en_r <= 1'b0;
            guarded_channel_select_r <= 5'h00;
            regular_done_irq_en_r <= 1'b0;
            threshold_alarm_irq_en_r <= 1'b0;
            injected_done_irq_en_r <= 1'b0;
            guard_single_channel_r <= 1'b0;
            auto_inject_enable_r <= 1'b0;
            guard_injected_enable_r <= 1'b0;
            guard_regular_enable_r <= 1'b0;
        end else if (wr && avs_address_i == adc_seq_pkg::ADR_CTRL2) begin
            power_on_bit_r <= wd[adc_seq_pkg::C2_PWR];
            repeat_mode_bit_r <= wd[adc_seq_pkg::C2_REP];
            pre_r <= wd[adc_seq_pkg::C2_PRE +: 2];
            temp_en_r <= wd[adc_seq_pkg::C2_TEMP];
            vbat_en_r <= wd[adc_seq_pkg::C2_VBAT];
        end else if (wr && avs_address_i == adc_seq_pkg::ADR_CTRL1) begin
            guarded_channel_select_r <= wd[adc_seq_pkg::C1_GSEL +: 5];
            regular_done_irq_en_r <= wd[adc_seq_pkg::C1_REGULAR_DONE_IRQ_EN];
            threshold_alarm_irq_en_r <= wd[adc_seq_pkg::C1_THRESHOLD_ALARM_IRQ_EN];
            injected_done_irq_en_r <= wd[adc_seq_pkg::C1_INJECTED_DONE_IRQ_EN];
            guard_single_channel_r <= wd[adc_seq_pkg::C1_GSGL];
            auto_inject_enable_r <= wd[adc_seq_pkg::C1_AUTO_INJECT_ENABLE];
            guard_injected_enable_r <= wd[adc_seq_pkg::C1_GJEN];
            guard_regular_enable_r <= wd[adc_seq_pkg::C1_GREN];
        end
    end

    // Sequence and threshold registers.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < NREG; i++) begin
                rseq_r[i] <= 5'h00;
            end
            for (int i = 0; i < NINJ; i++) begin
                jseq_r[i] <= 5'h00;
            end
            rlen_r <= 4'h0;
            jlen_r <= 2'h0;
            hthr_r <= adc_seq_pkg::RST_HTHR;
            lthr_r <= adc_seq_pkg::RST_LTHR;
        end else if (wr) begin
            case (avs_address_i)
                adc_seq_pkg::ADR_RSEQ0: begin
                    for (int i = 0; i < 6; i++) begin
                        rseq_r[i] <= wd[i*5 +: 5];
                    end
                end
                adc_seq_pkg::ADR_RSEQ1: begin
                    for (int i = 0; i < 6; i++) begin
                        rseq_r[i+6] <= wd[i*5 +: 5];
                    end
                end
                adc_seq_pkg::ADR_RSEQ2: begin
                    for (int i = 0; i < 4; i++) begin
                        rseq_r[i+12] <= wd[i*5 +: 5];
                    end
                    rlen_r <= wd[adc_seq_pkg::SQ_RLEN +: 4]; // [R07]
                end
                adc_seq_pkg::ADR_JSEQ: begin
                    for (int i = 0; i < NINJ; i++) begin
                        jseq_r[i] <= wd[i*5 +: 5];
                    end
                    jlen_r <= wd[adc_seq_pkg::SQ_JLEN +: 2]; // [R08]
                end
                adc_seq_pkg::ADR_HTHR: hthr_r <= wd[11:0]; // [R18]
                adc_seq_pkg::ADR_LTHR: lthr_r <= wd[11:0]; // [R18]
                default: ;
            endcase
        end
    end

    // Prescaler runs only while powered.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || state_r == adc_seq_pkg::ST_OFF) begin
            pc_r <= 3'h0;
        end else begin
            pc_r <= pc_nxt; // [R04]
        end
    end

    // Conversion sequencing.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || pwr_dn) begin
            state_r <= adc_seq_pkg::ST_OFF; // [R03]
            inj_r <= 1'b0;
            res_r <= 1'b0;
            idx_r <= 4'h0;
            sav_r <= 4'h0;
            cyc_r <= 4'h0;
        end else begin
            case (state_r)
                adc_seq_pkg::ST_OFF: begin
                    if (pwr_up) begin
                        state_r <= adc_seq_pkg::ST_IDLE; // [R01]
                    end
                end
                adc_seq_pkg::ST_IDLE: begin
                    cyc_r <= 4'h0;
                    idx_r <= 4'h0;
                    if (inj_start || reg_start) begin
                        state_r <= adc_seq_pkg::ST_CONV; // [R02]
                        inj_r <= inj_start;
                    end
                end
                adc_seq_pkg::ST_CONV: begin
                    if (seq_wr) begin
                        idx_r <= 4'h0; // [R09]
                        cyc_r <= 4'h0;
                    end else if (inj_start && !inj_r) begin
                        // Injection breaks into the regular group, which resumes later.
                        inj_r <= 1'b1;
                        res_r <= 1'b1;
                        sav_r <= idx_r;
                        idx_r <= 4'h0;
                        cyc_r <= 4'h0;
                    end else if (done) begin
                        cyc_r <= 4'h0;
                        if (!inj_r) begin
                            if (!rlast) begin
                                idx_r <= idx_r + 4'h1;
                            end else if (auto_inject_enable_r) begin
                                inj_r <= 1'b1; // [R16]
                                idx_r <= 4'h0;
                            end else if (repeat_mode_bit_r) begin
                                idx_r <= 4'h0; // [R15]
                            end else begin
                                state_r <= adc_seq_pkg::ST_IDLE; // [R12]
                            end
                        end else if (!jlast) begin
                            idx_r <= idx_r + 4'h1;
                        end else if (res_r) begin
                            inj_r <= 1'b0;
                            res_r <= 1'b0;
                            idx_r <= sav_r;
                        end else if (auto_inject_enable_r && repeat_mode_bit_r) begin
                            inj_r <= 1'b0; // [R16]
                            idx_r <= 4'h0;
                        end else begin
                            state_r <= adc_seq_pkg::ST_IDLE; // [R12] [R16]
                        end
                    end else begin
                        if (reg_start && inj_r && !res_r) begin
                            res_r <= 1'b1;
                            sav_r <= 4'h0;
                        end
                        if (tick) begin
                            cyc_r <= cyc_r + 4'h1; // [R17]
                        end
                    end
                end
                default: state_r <= adc_seq_pkg::ST_OFF;
            endcase
        end
    end

    // Results; regular data sit right-aligned in 16 bits.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rres_r <= 16'h0000;
            jres_r <= 16'h0000;
        end else if (done && !inj_r) begin
            rres_r <= {4'h0, result_i}; // [R13]
        end else if (done && inj_r) begin
            jres_r <= {4'h0, result_i}; // [R14]
        end
    end

    // Sticky flags, cleared by writing one; a set in the same cycle wins.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            eoc_r <= 1'b0;
            injected_done_flag_r <= 1'b0;
            threshold_alarm_flag_r <= 1'b0;
        end else begin
            if (done && !inj_r) begin
                eoc_r <= 1'b1; // [R13] [R17]
            end else if (wr && avs_address_i == adc_seq_pkg::ADR_STATUS
                    && wd[adc_seq_pkg::ST_EOC]) begin
                eoc_r <= 1'b0; // [R23]
            end
            if (done && inj_r) begin
                injected_done_flag_r <= 1'b1; // [R14]
            end else if (wr && avs_address_i == adc_seq_pkg::ADR_STATUS
                    && wd[adc_seq_pkg::ST_INJECTED_DONE_FLAG]) begin
                injected_done_flag_r <= 1'b0; // [R23]
            end
            if (done && guarded && out_range) begin
                threshold_alarm_flag_r <= 1'b1; // [R18] [R21]
            end else if (wr && avs_address_i == adc_seq_pkg::ADR_STATUS
                    && wd[adc_seq_pkg::ST_AWD]) begin
                threshold_alarm_flag_r <= 1'b0; // [R23]
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_eoc_r <= 1'b0;
            irq_injected_done_flag_r <= 1'b0;
            irq_awd_r <= 1'b0;
        end else begin
            irq_eoc_r <= eoc_r & regular_done_irq_en_r; // [R13] [R23]
            irq_injected_done_flag_r <= injected_done_flag_r & injected_done_irq_en_r; // [R14] [R23]
            irq_awd_r <= threshold_alarm_flag_r & threshold_alarm_irq_en_r; // [R19] [R23]
        end
    end

    // Analog core control.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ana_r <= '0;
        end else begin
            ana_r.power <= power_on_bit_r && !pwr_dn; // [R01] [R03]
            ana_r.conv_clk <= state_r != adc_seq_pkg::ST_OFF
                && pc_nxt <= {1'b0, pre_r}; // [R04]
            ana_r.convert <= state_r == adc_seq_pkg::ST_CONV && !seq_wr && !pwr_dn; // [R03]
            ana_r.channel <= cur_ch; // [R06]
            ana_r.vref_sel <= cur_ch == adc_seq_pkg::CH_VREF; // [R10]
            ana_r.vbat_sel <= vbat_en_r && (cur_ch == adc_seq_pkg::CH_TEMP_A
                || cur_ch == adc_seq_pkg::CH_TEMP_B); // [R11]
            ana_r.temp_sel <= temp_en_r && !vbat_en_r
                && (cur_ch == adc_seq_pkg::CH_TEMP_A
                || cur_ch == adc_seq_pkg::CH_TEMP_B); // [R11]
        end
    end

    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign ana_o = ana_r;
    assign irq_eoc_o = irq_eoc_r;
    assign irq_injected_done_flag_o = irq_injected_done_flag_r;
    assign irq_awd_o = irq_awd_r;
    // Keep acc visible for bus accounting.
    logic acc_unused;
    assign acc_unused = acc;
endmodule

//--- verification/adc_conv_seq_checker.sv
// Concurrent checks on the sequencer bus and analog control ports.
module adc_conv_seq_checker (
    input wire logic ref_clk_i, // Clock.
    input wire logic sys_rst_i, // Reset.
    input wire logic [3:0] avs_address_i, // Address.
    input wire logic avs_read_i, // Read.
    input wire logic avs_write_i, // Write.
    input wire logic [31:0] avs_readdata_o, // Read data.
    input wire logic avs_waitrequest_o, // Stall.
    input wire adc_seq_pkg::ana_ctrl_t ana_o // Analog control.
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered");
    unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i > 4'ha |-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read");
    start_reads_a: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i == 4'h2 |-> avs_readdata_o[5:4] == 2'h0) else $error("start bits read");
    off_idle_a: assert property (!ana_o.power |-> !ana_o.convert)
        else $error("converting while off");
    vbat_wins_a: assert property (ana_o.vbat_sel |-> !ana_o.temp_sel)
        else $error("both sensors selected");
    vref_chan_a: assert property (ana_o.vref_sel |-> ana_o.channel == 5'h11)
        else $error("reference on wrong channel");
    clk_runs_a: assert property (ana_o.power && $changed(ana_o.conv_clk) |->
        ##[1:4] ($changed(ana_o.conv_clk) || !ana_o.power)) else $error("clock too slow");
endmodule
bind adc_conv_seq adc_conv_seq_checker i_adc_conv_seq_checker (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ana_o(ana_o));

//--- verification/ana_core_model.sv
// Analog core model: channel-coded results, a toggling value when idle.
module ana_core_model (
    input wire logic ref_clk_i, // Clock.
    input wire adc_seq_pkg::ana_ctrl_t ana_i, // Control.
    output logic [11:0] result_o // Raw result.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial result_o = 12'h5a5;
    always @(posedge ref_clk_i) begin
        if (ana_i.power && ana_i.convert) begin
            result_o <= {ana_i.channel, 7'h2a};
        end else begin
            result_o <= ~result_o;
        end
    end
endmodule

//--- verification/adc_conv_seq_tb_top.sv
// Self-checking testbench of the conversion sequencer.
module adc_conv_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic wt;
    logic rtrig = 1'b0;
    logic jtrig = 1'b0;
    logic [11:0] res;
    adc_seq_pkg::ana_ctrl_t ana;
    logic [2:0] irqs;
    int miscompares = 0;
    int n_tests = 0;
    int cnt;
    int d;
    logic [31:0] q;
    adc_conv_seq i_adc_conv_seq (.ref_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .ext_reg_trig_i(rtrig), .ext_inj_trig_i(jtrig),
        .result_i(res), .ana_o(ana), .irq_eoc_o(irqs[0]), .irq_injected_done_flag_o(irqs[1]),
        .irq_awd_o(irqs[2]));
    ana_core_model i_ana_core_model (.ref_clk_i(clk), .ana_i(ana), .result_o(res));
    initial begin
        forever #2 clk = ~clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] dat);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= dat;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task wait_irq(input int k);
        cnt = 0;
        while (cnt < 400 && irqs[k] !== 1'b1) begin
            @(posedge clk);
            cnt++;
        end
    endtask
    task pulse(input logic inj);
        @(posedge clk);
        if (inj) jtrig <= 1'b1; else rtrig <= 1'b1;
        @(posedge clk);
        jtrig <= 1'b0;
        rtrig <= 1'b0;
    endtask
    task t_regs;
        bus(0, 4'h7, 0); chk(q, 32'h0000_0fff);
        bus(0, 4'h8, 0); chk(q, 32'h0000_0000);
        bus(0, 4'hd, 0); chk(q, 32'h0000_0000);
        bus(1, 4'h2, 32'h0000_0010);
        bus(0, 4'h0, 0); chk(q & 32'h18, 32'h0000_0000);
        bus(1, 4'h2, 32'h0000_0011);
        bus(0, 4'h0, 0); chk(q & 32'h18, 32'h0000_0008);
        $display("test regs done");
    endtask
    task t_single;
        bus(1, 4'h3, 32'h0000_0003);
        bus(1, 4'h5, 32'h0000_0000);
        bus(1, 4'h1, 32'h0000_0020);
        for (int p = 0; p < 4; p++) begin
            d = 2 * (p + 1);
            bus(1, 4'h2, 32'h0000_0011 | (p << 2));
            wait_irq(0); chk(cnt >= 14 * d && cnt <= 15 * d + 2, 1);
            bus(0, 4'h9, 0); chk(q, 32'h0000_01aa);
            chk(ana.convert, 1'b0);
            bus(1, 4'h0, 32'h0000_0001);
            repeat (2) @(posedge clk);
            chk(irqs[0], 1'b0);
        end
        $display("test single done");
    endtask
    task t_inject;
        bus(1, 4'h6, 32'h0000_0011);
        bus(1, 4'h3, 32'h0000_0010);
        bus(1, 4'h1, 32'h0000_00a0);
        bus(1, 4'h2, 32'h0000_00d3);
        pulse(1);
        wait_irq(1); chk(cnt < 400, 1);
        bus(0, 4'ha, 0); chk(q, 32'h0000_08aa);
        bus(1, 4'h0, 32'h0000_0003);
        repeat (2) @(posedge clk);
        wait_irq(0); chk(cnt < 400, 1);
        chk({ana.vbat_sel, ana.temp_sel}, 2'b10);
        repeat (70) @(posedge clk);
        chk(irqs[1], 1'b0);
        bus(1, 4'h2, 32'h0000_0000);
        @(posedge clk); chk(ana.convert, 1'b0);
        chk(ana.power, 1'b0);
        $display("test inject done");
    endtask
    task t_guard;
        bus(1, 4'h7, 32'h0000_0100);
        bus(1, 4'h1, 32'h0000_0840);
        bus(1, 4'h2, 32'h0000_0001);
        pulse(0);
        wait_irq(2); chk(cnt < 400, 1);
        bus(1, 4'h0, 32'h0000_0007);
        bus(1, 4'h1, 32'h0000_0040);
        pulse(0);
        repeat (40) @(posedge clk);
        chk(irqs[2], 1'b0);
        $display("test guard done");
    endtask
    task stop_test;
        $display("tests=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_single();
        t_inject();
        t_guard();
        stop_test();
    end
endmodule
